// >>> srft_pkg.sv
// shared constants and types for the row, frame and offset timing block
package srft_pkg;
    // ------------------------------------------------------------
    // timing figures
    // ------------------------------------------------------------
    localparam int SRFT_ROW_OVH = 19;
    localparam int SRFT_CLAMP_LIM = 719;
    localparam int SRFT_SF_STEP = 16;
    localparam int SRFT_DARK_SKIP = 2;
    localparam int SRFT_CLK_PERIOD_NS = 5;
    localparam int SRFT_SETTLE_NS = 137000;
    localparam int SRFT_SETTLE_CYC = (SRFT_SETTLE_NS + SRFT_CLK_PERIOD_NS - 1) / SRFT_CLK_PERIOD_NS;
    // ------------------------------------------------------------
    // widths and sizes
    // ------------------------------------------------------------
    localparam int SRFT_NUM_COLS = 704;
    localparam int SRFT_COL_W = 10;
    localparam int SRFT_COEF_W = 4;
    localparam int SRFT_GOFS_W = 5;
    localparam int SRFT_VCW_W = 12;
    localparam int SRFT_VRD_W = 12;
    localparam int SRFT_SH_W = 4;
    localparam int SRFT_CINT_W = 12;
    localparam int SRFT_SINT_W = 16;
    localparam int SRFT_CNT_W = 14;
    localparam int SRFT_DIV_W = 4;
    localparam int SRFT_SETTLE_W = 16;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [SRFT_CNT_W-1:0] SRFT_CNT_RST = 14'h0000;
    localparam logic [SRFT_VRD_W-1:0] SRFT_SLOT_RST = 12'h000;
    localparam logic [SRFT_GOFS_W-1:0] SRFT_OFS_RST = 5'h00;
    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SRFT_IDLE = 2'b00,
        SRFT_READ = 2'b01,
        SRFT_SF_INTEG = 2'b10,
        SRFT_SF_XFER = 2'b11
    } srft_state_t;
endpackage

// >>> srft_col_ram.sv
// per-column offset coefficient store, one write port, asynchronous read
`timescale 1ns/100ps
module srft_col_ram
    import srft_pkg::*;
#(
    parameter int DEPTH = SRFT_NUM_COLS,
    parameter int AW = SRFT_COL_W,
    parameter int DW = SRFT_COEF_W
) (
    input wire logic mclk_in,
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [DW-1:0] wr_data_in,
    input wire logic [AW-1:0] rd_addr_in,
    output logic [DW-1:0] rd_data_out
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [DW-1:0] mem [DEPTH];

    if (DEPTH > (1 << AW)) begin : g_chk
        $error("srft_col_ram: depth exceeds address range");
    end

    always_ff @(posedge mclk_in) begin
        if (wr_en_in && (int'(wr_addr_in) < DEPTH)) begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end

    always_comb begin
        if (int'(rd_addr_in) < DEPTH) begin
            rd_data_out = mem[rd_addr_in];
        end else begin
            rd_data_out = '0;
        end
    end
endmodule

// >>> srft_timing.sv
// row, frame clamp, integration timing and column offset control
`timescale 1ns/100ps
module srft_timing
    import srft_pkg::*;
#(
    parameter int SETTLE_CYCLES = SRFT_SETTLE_CYC,
    parameter int NUM_COLS = SRFT_NUM_COLS
) (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic [SRFT_VCW_W-1:0] vcw_in,
    input wire logic [SRFT_VRD_W-1:0] vrd_in,
    input wire logic [SRFT_SH_W-1:0] shs_in,
    input wire logic [SRFT_SH_W-1:0] shr_in,
    input wire logic [SRFT_CINT_W-1:0] cint_in,
    input wire logic [SRFT_SINT_W-1:0] sint_in,
    input wire logic single_frame_capture_in,
    input wire logic snap_start_in,
    input wire logic frame_black_clamp_dis_in,
    input wire logic per_column_en_in,
    input wire logic host_coef_mode_in,
    input wire logic [SRFT_GOFS_W-1:0] global_offset_in,
    input wire logic auto_coef_wr_in,
    input wire logic [SRFT_COEF_W-1:0] auto_coef_in,
    input wire logic coef_wr_in,
    input wire logic [SRFT_COL_W-1:0] coef_addr_in,
    input wire logic [SRFT_COEF_W-1:0] coef_data_in,
    output logic continuous_capture_out,
    output logic row_below_limit_out,
    output logic slot_start_out,
    output logic frame_start_out,
    output logic [SRFT_VRD_W-1:0] slot_index_out,
    output logic integ_reset_out,
    output logic [SRFT_VRD_W-1:0] integ_row_out,
    output logic global_reset_out,
    output logic transfer_out,
    output logic clamp_cap_a_out,
    output logic clamp_cap_b_out,
    output logic amp_cm_clamp_out,
    output logic clamp_settled_out,
    output logic col_valid_out,
    output logic [SRFT_COL_W-1:0] col_index_out,
    output logic [SRFT_GOFS_W-1:0] offset_adjust_out
);
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << SRFT_SETTLE_W)) begin : g_chk_settle
        $error("srft_timing: settle count out of range");
    end
    if (NUM_COLS < 1 || NUM_COLS > (1 << SRFT_COL_W)) begin : g_chk_cols
        $error("srft_timing: column count out of range");
    end

    // ------------------------------------------------------------
    // interval lengths
    // ------------------------------------------------------------
    logic [SRFT_CNT_W-1:0] row_len;
    logic [SRFT_CNT_W-1:0] clamp_len;
    logic [SRFT_CNT_W-1:0] slot_len;
    logic below_lim;

    assign row_len = SRFT_CNT_W'(vcw_in) + SRFT_CNT_W'(shs_in) + SRFT_CNT_W'(shr_in)
        + SRFT_CNT_W'(SRFT_ROW_OVH);
    assign clamp_len = SRFT_CNT_W'(SRFT_CLAMP_LIM) + SRFT_CNT_W'(shs_in) + SRFT_CNT_W'(shr_in)
        + SRFT_CNT_W'(SRFT_ROW_OVH);
    assign below_lim = row_len < SRFT_CNT_W'(SRFT_CLAMP_LIM);
    // slot 0 is the frame boundary slot: clamp interval or one extra row
    assign slot_len = (slot_index_out == SRFT_SLOT_RST && below_lim) ? clamp_len : row_len;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    srft_state_t state_reg, state_next;
    logic [SRFT_CNT_W-1:0] cyc_reg, cyc_next;
    logic [SRFT_VRD_W-1:0] slot_reg, slot_next;
    logic [SRFT_DIV_W-1:0] div_reg, div_next;
    logic [SRFT_SINT_W-1:0] step_reg, step_next;
    logic slot_start_reg, slot_start_next;
    logic frame_start_reg, frame_start_next;
    logic integ_reset_reg, integ_reset_next;
    logic [SRFT_VRD_W-1:0] integ_row_reg, integ_row_next;
    logic global_reset_reg, global_reset_next;
    logic xfer_reg, xfer_next;
    logic clamp_reg, clamp_next;
    logic [SRFT_SETTLE_W-1:0] settle_reg, settle_next;
    logic settled_reg, settled_next;
    logic [SRFT_VRD_W:0] isum;

    always_comb begin
        state_next = state_reg;
        cyc_next = cyc_reg;
        slot_next = slot_reg;
        div_next = div_reg;
        step_next = step_reg;
        slot_start_next = 1'b0;
        frame_start_next = 1'b0;
        global_reset_next = 1'b0;
        xfer_next = 1'b0;
        case (state_reg)
            SRFT_IDLE: begin
                if (!single_frame_capture_in) begin
                    state_next = SRFT_READ;
                    cyc_next = SRFT_CNT_RST;
                    slot_next = SRFT_SLOT_RST;
                    slot_start_next = 1'b1;
                    frame_start_next = 1'b1;
                end else if (snap_start_in) begin
                    global_reset_next = 1'b1;
                    div_next = '0;
                    step_next = '0;
                    if (sint_in == '0) begin
                        state_next = SRFT_SF_XFER;
                        xfer_next = 1'b1;
                    end else begin
                        state_next = SRFT_SF_INTEG;
                    end
                end
            end
            SRFT_READ: begin
                if (cyc_reg >= slot_len - 1'b1) begin
                    cyc_next = SRFT_CNT_RST;
                    slot_start_next = 1'b1;
                    if (slot_reg == vrd_in) begin
                        slot_next = SRFT_SLOT_RST;
                        if (single_frame_capture_in) begin
                            state_next = SRFT_IDLE;
                            slot_start_next = 1'b0;
                        end else begin
                            frame_start_next = 1'b1;
                        end
                    end else begin
                        slot_next = slot_reg + 1'b1;
                    end
                end else begin
                    cyc_next = cyc_reg + 1'b1;
                end
            end
            SRFT_SF_INTEG: begin
                // divider gives one step enable every 16 clocks
                div_next = div_reg + 1'b1;
                if (div_reg == SRFT_DIV_W'(SRFT_SF_STEP - 1)) begin
                    step_next = step_reg + 1'b1;
                    if (step_reg + 1'b1 == sint_in) begin
                        state_next = SRFT_SF_XFER;
                        xfer_next = 1'b1;
                    end
                end
            end
            SRFT_SF_XFER: begin
                state_next = SRFT_READ;
                cyc_next = SRFT_CNT_RST;
                slot_next = SRFT_SLOT_RST;
                slot_start_next = 1'b1;
                frame_start_next = 1'b1;
            end
            default: begin
                state_next = SRFT_IDLE;
            end
        endcase
        // rolling reset pointer leads the read slot by cint+1 slots
        isum = {1'b0, slot_next} + (SRFT_VRD_W+1)'(cint_in) + 1'b1;
        if (isum > {1'b0, vrd_in}) begin
            isum = isum - ({1'b0, vrd_in} + 1'b1);
        end
        if (isum > {1'b0, vrd_in}) begin
            isum = {1'b0, vrd_in};
        end
        integ_row_next = isum[SRFT_VRD_W-1:0];
        integ_reset_next = slot_start_next && !single_frame_capture_in;
        clamp_next = (state_next == SRFT_READ) && !frame_black_clamp_dis_in
            && (slot_next == SRFT_VRD_W'(SRFT_DARK_SKIP + 1));
        if (frame_black_clamp_dis_in) begin
            settle_next = '0;
        end else if (clamp_reg && settle_reg < SRFT_SETTLE_W'(SETTLE_CYCLES)) begin
            settle_next = settle_reg + 1'b1;
        end else begin
            settle_next = settle_reg;
        end
        settled_next = settle_next >= SRFT_SETTLE_W'(SETTLE_CYCLES);
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_reg <= SRFT_IDLE;
            cyc_reg <= SRFT_CNT_RST;
            slot_reg <= SRFT_SLOT_RST;
            div_reg <= '0;
            step_reg <= '0;
            slot_start_reg <= 1'b0;
            frame_start_reg <= 1'b0;
            integ_reset_reg <= 1'b0;
            integ_row_reg <= SRFT_SLOT_RST;
            global_reset_reg <= 1'b0;
            xfer_reg <= 1'b0;
            clamp_reg <= 1'b0;
            settle_reg <= '0;
            settled_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cyc_reg <= cyc_next;
            slot_reg <= slot_next;
            div_reg <= div_next;
            step_reg <= step_next;
            slot_start_reg <= slot_start_next;
            frame_start_reg <= frame_start_next;
            integ_reset_reg <= integ_reset_next;
            integ_row_reg <= integ_row_next;
            global_reset_reg <= global_reset_next;
            xfer_reg <= xfer_next;
            clamp_reg <= clamp_next;
            settle_reg <= settle_next;
            settled_reg <= settled_next;
        end
    end

    assign slot_index_out = slot_reg;
    assign slot_start_out = slot_start_reg;
    assign frame_start_out = frame_start_reg;
    assign integ_reset_out = integ_reset_reg;
    assign integ_row_out = integ_row_reg;
    assign global_reset_out = global_reset_reg;
    assign transfer_out = xfer_reg;
    assign clamp_cap_a_out = clamp_reg;
    assign clamp_cap_b_out = clamp_reg;
    assign amp_cm_clamp_out = clamp_reg;
    assign clamp_settled_out = settled_reg;

    // ------------------------------------------------------------
    // column offset path
    // ------------------------------------------------------------
    logic col_live;
    logic [SRFT_COL_W-1:0] col_addr;
    logic ram_wr;
    logic [SRFT_COL_W-1:0] ram_waddr;
    logic [SRFT_COEF_W-1:0] ram_wdata;
    logic [SRFT_COEF_W-1:0] coef;
    logic col_valid_reg, col_valid_next;
    logic [SRFT_COL_W-1:0] col_reg, col_next;
    logic [SRFT_GOFS_W-1:0] ofs_reg, ofs_next;
    logic mode_reg, mode_next;
    logic lim_reg, lim_next;

    assign col_live = (state_reg == SRFT_READ) && (slot_reg != SRFT_SLOT_RST)
        && (cyc_reg < SRFT_CNT_W'(NUM_COLS));
    assign col_addr = cyc_reg[SRFT_COL_W-1:0];

    always_comb begin
        // host writes win over the automatic generator
        if (coef_wr_in) begin
            ram_wr = 1'b1;
            ram_waddr = coef_addr_in;
            ram_wdata = coef_data_in;
        end else begin
            ram_wr = auto_coef_wr_in && !host_coef_mode_in && col_live;
            ram_waddr = col_addr;
            ram_wdata = auto_coef_in;
        end
        col_valid_next = col_live;
        col_next = col_live ? col_addr : '0;
        if (per_column_en_in) begin
            // 4-bit sign/magnitude widened to the 5-bit sign/magnitude lane
            ofs_next = {coef[SRFT_COEF_W-1], 1'b0, coef[SRFT_COEF_W-2:0]};
        end else begin
            ofs_next = global_offset_in;
        end
        mode_next = (state_next != SRFT_IDLE || !single_frame_capture_in)
            && !single_frame_capture_in;
        lim_next = below_lim;
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            col_valid_reg <= 1'b0;
            col_reg <= '0;
            ofs_reg <= SRFT_OFS_RST;
            mode_reg <= 1'b1;
            lim_reg <= 1'b0;
        end else begin
            col_valid_reg <= col_valid_next;
            col_reg <= col_next;
            ofs_reg <= ofs_next;
            mode_reg <= mode_next;
            lim_reg <= lim_next;
        end
    end

    assign col_valid_out = col_valid_reg;
    assign col_index_out = col_reg;
    assign offset_adjust_out = ofs_reg;
    assign continuous_capture_out = mode_reg;
    assign row_below_limit_out = lim_reg;

    srft_col_ram #(
        .DEPTH(NUM_COLS),
        .AW(SRFT_COL_W),
        .DW(SRFT_COEF_W)
    ) i_srft_col_ram (
        .mclk_in(mclk_in),
        .wr_en_in(ram_wr),
        .wr_addr_in(ram_waddr),
        .wr_data_in(ram_wdata),
        .rd_addr_in(col_addr),
        .rd_data_out(coef)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    logic [SRFT_SINT_W+SRFT_DIV_W-1:0] sf_cnt_reg;
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sf_cnt_reg <= '0;
        end else if (global_reset_next) begin
            sf_cnt_reg <= '0;
        end else if (state_reg == SRFT_SF_INTEG) begin
            sf_cnt_reg <= sf_cnt_reg + 1'b1;
        end
    end

    sequence snap_go;
        state_reg == SRFT_IDLE && single_frame_capture_in && snap_start_in;
    endsequence
    sequence snap_fire;
        global_reset_out;
    endsequence

    row_time_end_a: assert property ((state_reg == SRFT_READ) && slot_reg != '0
        && cyc_reg == row_len - 1'b1
        |=> cyc_reg == '0 && (slot_start_out || state_reg == SRFT_IDLE))
        else $error("row did not end at programmed length");
    clamp_slot_a: assert property ((state_reg == SRFT_READ) && slot_reg == 0 && below_lim
        && cyc_reg == clamp_len - 1'b1 && vrd_in != 0 |=> slot_reg == 1)
        else $error("clamp interval length wrong");
    limit_cmp_a: assert property (slot_start_out && slot_reg == 0
        |-> ##1 (row_below_limit_out == (row_len < SRFT_CNT_W'(SRFT_CLAMP_LIM)) || $changed(vcw_in)))
        else $error("clamp limit comparison wrong");
    frame_wrap_a: assert property (frame_start_out |-> slot_reg == 0 && cyc_reg == 0)
        else $error("frame start off the boundary slot");
    snap_start_a: assert property (snap_go |=> snap_fire)
        else $error("snapshot did not start integration");
    sf_integ_a: assert property (transfer_out |-> sf_cnt_reg == 20'(sint_in) * 20'h10)
        else $error("single-frame integration length wrong");
    dark_row_a: assert property (clamp_cap_a_out |-> slot_reg == SRFT_VRD_W'(SRFT_DARK_SKIP + 1)
        && amp_cm_clamp_out)
        else $error("clamp outside third dark row");
    clamp_off_a: assert property (frame_black_clamp_dis_in [*2] |-> !clamp_cap_a_out
        && !clamp_settled_out)
        else $error("clamp active while disabled");
    settle_gate_a: assert property (clamp_settled_out |-> settle_reg >= SETTLE_CYCLES)
        else $error("settled flag raised early");
    global_ofs_a: assert property (!per_column_en_in |=> offset_adjust_out
        == $past(global_offset_in))
        else $error("global offset not applied");
endmodule

// >>> srft_host_model.sv
// host model: programs timing values and measures slot, frame and clamp lengths
`timescale 1ns/100ps
module srft_host_model (
    input wire logic mclk_in,
    input wire logic slot_start_in,
    input wire logic frame_start_in,
    input wire logic [11:0] slot_index_in,
    input wire logic clamp_in,
    output logic [3:0] shs_out,
    output logic [3:0] shr_out,
    output logic [15:0] slot0_len_out,
    output logic [15:0] slot1_len_out,
    output logic [15:0] frame_len_out,
    output logic [15:0] clamp_len_out
);
    logic [15:0] scnt_reg, fcnt_reg, ccnt_reg;

    // internal timing values left at zero as advised
    assign shs_out = 4'h0;
    assign shr_out = 4'h0;

    // ----------------------------------------
    // lengths of the slot and frame just closed, and clamp cycles in that frame
    // ----------------------------------------
    always @(posedge mclk_in) begin
        scnt_reg <= scnt_reg + 16'h0001;
        fcnt_reg <= fcnt_reg + 16'h0001;
        ccnt_reg <= ccnt_reg + {15'h0000, clamp_in};
        if (slot_start_in) begin
            scnt_reg <= 16'h0001;
            if (slot_index_in == 12'h001) slot0_len_out <= scnt_reg;
            if (slot_index_in == 12'h002) slot1_len_out <= scnt_reg;
        end
        if (frame_start_in) begin
            fcnt_reg <= 16'h0001;
            ccnt_reg <= 16'h0000;
            frame_len_out <= fcnt_reg;
            clamp_len_out <= ccnt_reg;
        end
    end
endmodule

// >>> tb.sv
// self-checking testbench for the row, frame and offset timing block
`timescale 1ns/100ps
module tb;
    import srft_pkg::*;
    localparam int SETTLE = 20;
    logic mclk = 1'b0, rst_b = 1'b0, single = 1'b0, snap = 1'b0, clamp_dis = 1'b0;
    logic per_col = 1'b0, host_mode = 1'b0, auto_wr = 1'b0, coef_wr = 1'b0;
    logic [11:0] vcw = 12'h014, vrd = 12'h004, cint = 12'h001;
    logic [15:0] sint = 16'h0003;
    logic [4:0] gofs = 5'h00;
    logic [3:0] auto_coef = 4'h7, coef_data = 4'h0, shs, shr;
    logic [9:0] coef_addr = 10'h000;
    logic cc, below, slot_st, frame_st, ireset, greset, xfer, cap_a, cap_b, cm, settled, col_v;
    logic [11:0] slot_idx, irow;
    logic [9:0] col_idx;
    logic [4:0] ofs;
    logic [15:0] s0_len, s1_len, f_len, c_len;
    int n_mismatch = 0, comparisons = 0, cycles = 0;

    always #2.5 mclk = ~mclk;

    srft_timing #(.SETTLE_CYCLES(SETTLE)) i_srft_timing (
        .mclk_in(mclk), .rst_b_in(rst_b), .vcw_in(vcw), .vrd_in(vrd), .shs_in(shs),
        .shr_in(shr), .cint_in(cint), .sint_in(sint), .single_frame_capture_in(single),
        .snap_start_in(snap), .frame_black_clamp_dis_in(clamp_dis), .per_column_en_in(per_col),
        .host_coef_mode_in(host_mode), .global_offset_in(gofs), .auto_coef_wr_in(auto_wr),
        .auto_coef_in(auto_coef), .coef_wr_in(coef_wr), .coef_addr_in(coef_addr),
        .coef_data_in(coef_data), .continuous_capture_out(cc), .row_below_limit_out(below),
        .slot_start_out(slot_st), .frame_start_out(frame_st), .slot_index_out(slot_idx),
        .integ_reset_out(ireset), .integ_row_out(irow), .global_reset_out(greset),
        .transfer_out(xfer), .clamp_cap_a_out(cap_a), .clamp_cap_b_out(cap_b),
        .amp_cm_clamp_out(cm), .clamp_settled_out(settled), .col_valid_out(col_v),
        .col_index_out(col_idx), .offset_adjust_out(ofs));

    srft_host_model i_srft_host_model (
        .mclk_in(mclk), .slot_start_in(slot_st), .frame_start_in(frame_st),
        .slot_index_in(slot_idx), .clamp_in(cap_a), .shs_out(shs), .shr_out(shr),
        .slot0_len_out(s0_len), .slot1_len_out(s1_len), .frame_len_out(f_len),
        .clamp_len_out(c_len));

    // ----------------------------------------
    // shared helpers
    // ----------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic chk(input bit ok, input string msg);
        comparisons++;
        if (!ok) begin
            n_mismatch++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic wait_frame(input int n);
        int k;
        k = 0;
        while (n > 0 && k < 20000) begin
            step(1);
            k++;
            if (frame_st === 1'b1) n--;
        end
        chk(k < 20000, "frame start missing");
    endtask

    task automatic wait_slot(input logic [11:0] s);
        int k;
        k = 0;
        while (!(slot_st === 1'b1 && slot_idx === s) && k < 20000) begin
            step(1);
            k++;
        end
        chk(k < 20000, "slot never reached");
    endtask

    task automatic wait_col(input logic [9:0] c);
        int k;
        k = 0;
        while (!(col_v === 1'b1 && col_idx === c) && k < 5000) begin
            step(1);
            k++;
        end
        chk(k < 5000, "column never reached");
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        step(20);
        chk(cc === 1'b1 && slot_st === 1'b0 && greset === 1'b0, "reset outputs");
        chk(settled === 1'b0 && cap_a === 1'b0, "reset clamp");
        rst_b = 1'b1;
    endtask

    task automatic t_short();
        int ovh, row;
        ovh = int'(shs) + int'(shr) + SRFT_ROW_OVH;
        row = int'(vcw) + ovh;
        wait_frame(3);
        chk(below === 1'b1, "short row flag");
        chk(s1_len === 16'(row), "row time");
        chk(s0_len === 16'(SRFT_CLAMP_LIM + ovh), "clamp interval");
        chk(f_len === 16'(SRFT_CLAMP_LIM + ovh + int'(vrd) * row), "short frame");
        chk(c_len === 16'(row), "one dark row clamped per frame");
        wait_slot(12'h002);
        step(2);
        chk(cap_a === 1'b0, "skipped dark row");
        wait_slot(12'h003);
        step(2);
        chk(cap_a === 1'b1 && cap_b === 1'b1 && cm === 1'b1, "clamp on third row");
        chk(settled === 1'b1, "clamp settled");
    endtask

    task automatic t_disable();
        clamp_dis = 1'b1;
        wait_frame(2);
        step(1);
        chk(c_len === 16'h0000 && settled === 1'b0, "clamp disabled");
        clamp_dis = 1'b0;
        wait_slot(12'h003);
        step(2);
        chk(cap_a === 1'b1 && settled === 1'b0, "settle restarts");
        step(30);
        chk(settled === 1'b1, "settle reached");
    endtask

    task automatic t_long();
        vcw = 12'(SRFT_CLAMP_LIM - SRFT_ROW_OVH);
        wait_frame(3);
        chk(below === 1'b0, "row at limit");
        chk(s0_len === 16'(SRFT_CLAMP_LIM), "long first slot");
        chk(f_len === 16'((int'(vrd) + 1) * SRFT_CLAMP_LIM), "long frame");
        wait_slot(12'h001);
        chk(ireset === 1'b1 && irow === 12'((int'(cint) + 2) % (int'(vrd) + 1)), "integ row");
        vcw = 12'h014;
        wait_frame(2);
    endtask

    task automatic t_single();
        int k;
        single = 1'b1;
        step(1000);
        chk(cc === 1'b0, "single mode");
        snap = 1'b1;
        step(1);
        snap = 1'b0;
        k = 0;
        while (greset !== 1'b1 && k < 10) begin
            step(1);
            k++;
        end
        chk(k < 10, "global reset");
        k = 0;
        while (xfer !== 1'b1 && k < 200) begin
            step(1);
            k++;
        end
        chk(k == int'(sint) * SRFT_SF_STEP, "single integration");
        step(1);
        chk(frame_st === 1'b1, "readout after transfer");
        step(1000);
        sint = 16'h0000;
        snap = 1'b1;
        step(1);
        snap = 1'b0;
        chk(greset === 1'b1 && xfer === 1'b1, "zero-length integration");
        step(1);
        chk(frame_st === 1'b1, "readout after zero integration");
        sint = 16'h0003;
        single = 1'b0;
    endtask

    task automatic t_coef();
        host_mode = 1'b1;
        auto_wr = 1'b1;
        per_col = 1'b1;
        coef_wr = 1'b1;
        coef_addr = 10'h005;
        coef_data = 4'hb;
        step(1);
        coef_wr = 1'b0;
        step(1000);
        wait_col(10'h005);
        chk(ofs === {coef_data[3], 1'b0, coef_data[2:0]}, "host coefficient");
        host_mode = 1'b0;
        step(1000);
        wait_col(10'h005);
        chk(ofs === {auto_coef[3], 1'b0, auto_coef[2:0]}, "auto coefficient");
        per_col = 1'b0;
        gofs = 5'h15;
        step(2);
        wait_col(10'h006);
        chk(ofs === gofs, "global offset");
        auto_wr = 1'b0;
    endtask

    task automatic conclude();
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles >= 60000) begin
            n_mismatch++;
            $display("[ERR] %0t run too long", $time);
            conclude();
        end
    end

    initial begin
        t_reset();
        t_short();
        t_disable();
        t_long();
        t_single();
        t_coef();
        conclude();
    end
endmodule
